// ### logic/rcs_reset_cause_options.sv
// Reset-cause status and system-option registers behind an AXI4-Lite slave.
// Assumes all event inputs are synchronous one-cycle pulses on aclk and that
// the chip reset controller answers mcu_reset_req by pulsing aresetn low.
//
// Notes on behaviour
// - Illegal opcode reset sets cause bit 4
// - Stop is illegal while stop disabled
// - Background entry illegal while debug disabled
// - Illegal address access sets cause bit 3
// - Wake-up reset flagged, except during stop1
// - Low voltage or power-on sets bit 1
// - Cause bit 0 always reads zero
// - Option bit 7 enables watchdog, resets one
// - Watchdog and stop bits write once
// - Option bit 6 picks watchdog clock
// - Option bit 5 allows stop entry
// - Radio bit survives every MCU reset
// - Option bit 3 enables thermal restart
// - Option bit 2 picks thermal direction
// - Option bit 1 gives pin to debug
// - Option bit 0 always reads one
// - Cause write restarts watchdog, keeps flags
// - Each reset rewrites all cause flags
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module rcs_reset_cause_options (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_on_reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic undefined_opcode_exec,
   input wire logic stop_instr_exec,
   input wire logic background_entry_instruction,
   input wire logic debug_mode_enable,
   input wire logic illegal_address_access,
   input wire logic wakeup_reset_event,
   input wire logic in_stop1,
   input wire logic low_voltage_trip,
   input wire logic low_voltage_reset_enable,
   input wire logic low_voltage_stop_enable,
   output logic mcu_reset_req,
   output logic stop_mode_entry,
   output logic watchdog_restart,
   output logic watchdog_enable,
   output logic watchdog_clock_select,
   output logic stop_mode_enable,
   output logic radio_enable,
   output logic thermal_restart_enable,
   output logic thermal_restart_level,
   output logic debug_pin_enable,
   output logic irq
);

   logic [7:0] cause_q;
   logic [7:0] pending_q;
   logic [7:0] pending_d;
   logic [7:0] option_q;
   logic radio_q;
   logic lock_q;
   logic first_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_mask_q;
   logic [1:0] irq_set;
   logic opcode_bad;
   logic wr_fire;
   logic rd_fire;
   logic wr_opt;
   logic [7:0] option_view;
   logic [7:0] rd_word;
   logic rd_hit;

   // Register view of the option byte, reserved bit forced high
   assign option_view = {option_q[7:5], radio_q, option_q[3:1], 1'b0}
                        | rcs_pkg::OPTION_RESERVED;

   // Illegal opcode sources, stop and background gated by their enables
   assign opcode_bad = undefined_opcode_exec
                       | (stop_instr_exec & ~option_q[rcs_pkg::OPT_STOP_ENABLE])
                       | (background_entry_instruction & ~debug_mode_enable);

   // Reset causes requested this cycle; wake-ups during stop1 are not flagged
   always_comb begin
      pending_d = 8'h00;
      pending_d[rcs_pkg::CAUSE_ILLEGAL_OPCODE] = opcode_bad;
      pending_d[rcs_pkg::CAUSE_ILLEGAL_ADDRESS] = illegal_address_access;
      pending_d[rcs_pkg::CAUSE_WAKEUP] = wakeup_reset_event & ~in_stop1;
      pending_d[rcs_pkg::CAUSE_LOW_VOLTAGE] = low_voltage_trip
                                               & low_voltage_reset_enable
                                               & low_voltage_stop_enable;
   end

   // Pending causes live across the MCU reset; power-on loads only the power-on cause.
   // Cleared only once reset is released, so a long reset keeps its causes.
   always_ff @(posedge aclk) begin
      if (power_on_reset) begin
         pending_q <= rcs_pkg::POR_PENDING;
      end else if (first_q && aresetn) begin
         pending_q <= 8'h00;
      end else begin
         pending_q <= pending_q | pending_d;
      end
   end

   // Reset request to the chip reset controller
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mcu_reset_req <= 1'b0;
      end else begin
         mcu_reset_req <= |pending_d;
      end
   end

   // Marks the first cycle after reset release, when causes are captured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // Cause flags rewritten whole from the pending set; bit 0 never set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_q <= rcs_pkg::CAUSE_RESET;
      end else if (first_q) begin
         cause_q <= {3'h0, pending_q[4:1], 1'b0};
      end
   end

   // Bus handshakes: address and data taken together, one at a time
   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign wr_fire = s_axi_awready;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign wr_opt = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr == rcs_pkg::OFF_OPTION);

   // Write-once lock; no write path clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 1'b0;
      end else if (wr_opt) begin
         lock_q <= 1'b1;
      end
   end

   // Option bits; locked fields keep their value after the first write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_q <= rcs_pkg::OPTION_RESET;
      end else if (wr_opt) begin
         if (!lock_q) begin
            option_q[7:5] <= s_axi_wdata[7:5];
         end
         option_q[3:1] <= s_axi_wdata[3:1];
      end
   end

   // Radio enable ignores MCU reset, only power-on initialises it
   always_ff @(posedge aclk) begin
      if (power_on_reset) begin
         radio_q <= 1'b0;
      end else if (wr_opt) begin
         radio_q <= s_axi_wdata[rcs_pkg::OPT_RADIO_ENABLE];
      end
   end

   // Option outputs
   assign watchdog_enable = option_q[rcs_pkg::OPT_WATCHDOG_ENABLE];
   assign watchdog_clock_select = option_q[rcs_pkg::OPT_WATCHDOG_CLOCK];
   assign stop_mode_enable = option_q[rcs_pkg::OPT_STOP_ENABLE];
   assign radio_enable = radio_q;
   assign thermal_restart_enable = option_q[rcs_pkg::OPT_THERMAL_ENABLE];
   assign thermal_restart_level = option_q[rcs_pkg::OPT_THERMAL_LEVEL];
   assign debug_pin_enable = option_q[rcs_pkg::OPT_DEBUG_PIN];

   // Stop entry and watchdog restart pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_mode_entry <= 1'b0;
         watchdog_restart <= 1'b0;
      end else begin
         stop_mode_entry <= stop_instr_exec & option_q[rcs_pkg::OPT_STOP_ENABLE];
         watchdog_restart <= wr_fire & (s_axi_awaddr == rcs_pkg::OFF_CAUSE);
      end
   end

   // Interrupt events: refused locked write, nonzero cause captured
   assign irq_set[rcs_pkg::IRQ_LOCKED_WRITE] = wr_opt & lock_q
                                               & (s_axi_wdata[7:5] != option_q[7:5]);
   assign irq_set[rcs_pkg::IRQ_CAUSE_CAPTURED] = first_q & (|pending_q[4:1]);

   // Sticky status, cleared by reading it; a new event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= rcs_pkg::IRQ_RESET;
      end else if (rd_fire && s_axi_araddr == rcs_pkg::OFF_IRQ_STATUS) begin
         irq_status_q <= irq_set;
      end else begin
         irq_status_q <= irq_status_q | irq_set;
      end
   end

   // Interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= rcs_pkg::IRQ_RESET;
      end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == rcs_pkg::OFF_IRQ_MASK) begin
         irq_mask_q <= s_axi_wdata[1:0];
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rcs_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (s_axi_awaddr == rcs_pkg::OFF_CAUSE
                         || s_axi_awaddr == rcs_pkg::OFF_OPTION
                         || s_axi_awaddr == rcs_pkg::OFF_IRQ_STATUS
                         || s_axi_awaddr == rcs_pkg::OFF_IRQ_MASK)
                        ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode
   always_comb begin
      rd_word = 8'h00;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         rcs_pkg::OFF_CAUSE: rd_word = cause_q;
         rcs_pkg::OFF_OPTION: rd_word = option_view;
         rcs_pkg::OFF_IRQ_STATUS: rd_word = {6'h00, irq_status_q};
         rcs_pkg::OFF_IRQ_MASK: rd_word = {6'h00, irq_mask_q};
         default: rd_hit = 1'b0;
      endcase
   end

   // Read data registered, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= rcs_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_word};
         s_axi_rresp <= rd_hit ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : rcs_reset_cause_options

// ### logic/rcs_pkg.sv
// Constants for the reset-cause and system-option register block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package rcs_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CAUSE = 8'h00;
   localparam logic [7:0] OFF_OPTION = 8'h04;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

   // Reset-cause field positions
   localparam int CAUSE_ILLEGAL_OPCODE = 4;
   localparam int CAUSE_ILLEGAL_ADDRESS = 3;
   localparam int CAUSE_WAKEUP = 2;
   localparam int CAUSE_LOW_VOLTAGE = 1;

   // Option field positions
   localparam int OPT_WATCHDOG_ENABLE = 7;
   localparam int OPT_WATCHDOG_CLOCK = 6;
   localparam int OPT_STOP_ENABLE = 5;
   localparam int OPT_RADIO_ENABLE = 4;
   localparam int OPT_THERMAL_ENABLE = 3;
   localparam int OPT_THERMAL_LEVEL = 2;
   localparam int OPT_DEBUG_PIN = 1;

   // Interrupt status field positions
   localparam int IRQ_LOCKED_WRITE = 0;
   localparam int IRQ_CAUSE_CAPTURED = 1;

   // Values after reset
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'h80;
   localparam logic [7:0] OPTION_RESERVED = 8'h01;
   localparam logic [7:0] POR_PENDING = 8'h02;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rcs_pkg

// ### verif/rcs_reset_cause_options_properties.sv
// Checker for the reset-cause and option block, bound to its top ports.
// Assumes event inputs are one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
module rcs_reset_cause_options_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_on_reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic undefined_opcode_exec,
   input wire logic stop_instr_exec,
   input wire logic background_entry_instruction,
   input wire logic debug_mode_enable,
   input wire logic illegal_address_access,
   input wire logic mcu_reset_req,
   input wire logic stop_mode_entry,
   input wire logic watchdog_restart,
   input wire logic watchdog_enable,
   input wire logic watchdog_clock_select,
   input wire logic stop_mode_enable,
   input wire logic radio_enable
);
   default clocking cb @(posedge aclk); endclocking
   // Write taken in the same cycle that it is aimed at the cause register
   sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wready; endsequence
   sequence s_wr0; s_wtake ##0 s_axi_awaddr == rcs_pkg::OFF_CAUSE; endsequence
   // Event properties; reset ones carry no disable, they check the reset itself
   property p_opc; disable iff (!aresetn) undefined_opcode_exec |=> mcu_reset_req; endproperty
   property p_stop_bad; disable iff (!aresetn)
      stop_instr_exec && !stop_mode_enable |=> mcu_reset_req && !stop_mode_entry; endproperty
   property p_stop_ok; disable iff (!aresetn)
      stop_instr_exec && stop_mode_enable |=> stop_mode_entry && !mcu_reset_req; endproperty
   property p_background_entry_instruction; disable iff (!aresetn)
      background_entry_instruction && !debug_mode_enable |=> mcu_reset_req; endproperty
   property p_addr; disable iff (!aresetn) illegal_address_access |=> mcu_reset_req; endproperty
   property p_wdog; disable iff (!aresetn) s_wr0 |=> watchdog_restart; endproperty
   property p_rstval;
      !aresetn |=> watchdog_enable && !watchdog_clock_select && !stop_mode_enable; endproperty
   property p_radio; !aresetn && !power_on_reset |=> $stable(radio_enable); endproperty
   a_opc: assert property (p_opc) else $error("opcode fault without reset");
   a_stop_bad: assert property (p_stop_bad) else $error("stop not refused");
   a_stop_ok: assert property (p_stop_ok) else $error("stop not entered");
   a_background_entry_instruction: assert property (p_background_entry_instruction) else $error("debug entry not refused");
   a_addr: assert property (p_addr) else $error("address fault without reset");
   a_wdog: assert property (p_wdog) else $error("no watchdog restart");
   a_rstval: assert property (p_rstval) else $error("bad option reset");
   a_radio: assert property (p_radio) else $error("radio bit lost in reset");
endmodule : rcs_reset_cause_options_properties
bind rcs_reset_cause_options rcs_reset_cause_options_properties u_props (.aclk, .aresetn,
   .power_on_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
   .undefined_opcode_exec, .stop_instr_exec, .background_entry_instruction, .debug_mode_enable,
   .illegal_address_access, .mcu_reset_req, .stop_mode_entry, .watchdog_restart,
   .watchdog_enable, .watchdog_clock_select, .stop_mode_enable, .radio_enable);

// ### verif/testbench.sv
// Self-checking bench for the reset-cause and option register block.
// Assumes one AXI4-Lite response per request, returned in order.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, power_on_reset = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, lvl = 4'h0;
   logic [5:0] ev = 6'h00;
   logic [6:0] opt;
   logic [1:0] s_axi_bresp, s_axi_rresp, be;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic mcu_reset_req, stop_mode_entry, watchdog_restart, irq;
   logic [33:0] rq[$], re;
   logic [1:0] wq[$];
   int mismatches = 0, compares = 0, seed = 32'hAA9080CF;
   rcs_reset_cause_options dut_u (.aclk, .aresetn, .power_on_reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .undefined_opcode_exec(ev[0]), .stop_instr_exec(ev[1]),
      .background_entry_instruction(ev[2]), .debug_mode_enable(lvl[0]),
      .illegal_address_access(ev[3]), .wakeup_reset_event(ev[4]), .in_stop1(lvl[1]),
      .low_voltage_trip(ev[5]), .low_voltage_reset_enable(lvl[2]),
      .low_voltage_stop_enable(lvl[3]), .mcu_reset_req, .stop_mode_entry, .watchdog_restart,
      .watchdog_enable(opt[6]), .watchdog_clock_select(opt[5]), .stop_mode_enable(opt[4]),
      .radio_enable(opt[3]), .thermal_restart_enable(opt[2]),
      .thermal_restart_level(opt[1]), .debug_pin_enable(opt[0]), .irq);
   // 125 MHz bus clock
   always #4 aclk = ~aclk;
   // Oldest note is compared when a response is taken; popped once, compared once
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         re = rq.pop_front();
         `CHK("read", re, {s_axi_rresp, s_axi_rdata})
      end
      if (s_axi_bvalid && s_axi_bready) begin
         be = wq.pop_front();
         `CHK("bresp", be, s_axi_bresp)
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wq.push_back(rcs_pkg::RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input logic [1:0] r = rcs_pkg::RESP_OKAY);
      rq.push_back({r, 24'h0, e});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic opt_rd(input logic [7:0] e);
      rd(rcs_pkg::OFF_OPTION, e);
      `CHK("option pins", e[7:1], opt)
   endtask : opt_rd
   // Pulses with their qualifying levels, then a quiet cycle before any reset
   task automatic fire(input logic [5:0] e, input logic [3:0] l);
      @(posedge aclk);
      lvl <= l;
      ev <= e;
      @(posedge aclk);
      ev <= 6'h00;
      @(posedge aclk);
   endtask : fire
   task automatic rst(input logic p);
      @(posedge aclk);
      aresetn <= 1'b0;
      power_on_reset <= p;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_reset <= 1'b0;
      @(posedge aclk);
   endtask : rst
   task automatic end_sim;
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   // Hang guard, far beyond the roughly ninety cycles the sequence needs
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
   // Main sequence: power-on, locking, interrupt, then two MCU resets
   initial begin
      rst(1'b1);
      rd(rcs_pkg::OFF_CAUSE, 8'h02);
      opt_rd(8'h81);
      rd(8'h10, 8'h00, rcs_pkg::RESP_SLVERR);
      wr(rcs_pkg::OFF_OPTION, 32'h7E);
      opt_rd(8'h7F);
      wr(rcs_pkg::OFF_IRQ_MASK, 32'h3);
      wr(rcs_pkg::OFF_OPTION, 32'h90);
      opt_rd(8'h71);
      `CHK("irq", 1'b1, irq)
      rd(rcs_pkg::OFF_IRQ_STATUS, 8'h03);
      @(posedge aclk);
      `CHK("irq", 1'b0, irq)
      wr(rcs_pkg::OFF_IRQ_MASK, 32'h2);
      wr(rcs_pkg::OFF_OPTION, 32'h90);
      @(posedge aclk);
      `CHK("irq", 1'b0, irq)
      wr(rcs_pkg::OFF_IRQ_MASK, 32'h1);
      @(posedge aclk);
      `CHK("irq", 1'b1, irq)
      rd(rcs_pkg::OFF_IRQ_STATUS, 8'h01);
      wr(rcs_pkg::OFF_CAUSE, $random(seed));
      rd(rcs_pkg::OFF_CAUSE, 8'h02);
      fire(6'h02, 4'h0);
      fire(6'h39, 4'hC);
      rst(1'b0);
      rd(rcs_pkg::OFF_CAUSE, 8'h1E);
      opt_rd(8'h91);
      wr(rcs_pkg::OFF_OPTION, 32'h00);
      opt_rd(8'h01);
      fire(6'h36, 4'h6);
      rst(1'b0);
      rd(rcs_pkg::OFF_CAUSE, 8'h10);
      end_sim();
   end
endmodule : testbench
